// [common/fps_pkg.sv]
package fps_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] FPS_ADDR_DUTY1 = 8'h30;
    localparam logic [7:0] FPS_ADDR_DUTY2 = 8'h31;
    localparam logic [7:0] FPS_ADDR_DUTY3 = 8'h32;
    localparam logic [7:0] FPS_ADDR_SUBST = 8'h36;
    localparam logic [7:0] FPS_ADDR_CFG1 = 8'h40;
    localparam logic [7:0] FPS_ADDR_CH1 = 8'h5c;
    localparam logic [7:0] FPS_ADDR_CH2 = 8'h5d;
    localparam logic [7:0] FPS_ADDR_CH3 = 8'h5e;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int FPS_SEL_LSB = 5;
    localparam int FPS_SEL_MSB = 7;
    localparam int FPS_ALT_BIT = 3;
    localparam int FPS_SUBST_BIT = 4;
    localparam int FPS_LOCK_BIT = 0;
    localparam logic [7:0] FPS_CH_RESET = 8'h62;
    localparam logic [7:0] FPS_DUTY_RESET = 8'hff;
    localparam logic [7:0] FPS_ZERO8 = 8'h00;
    localparam logic [7:0] FPS_FULL_DUTY = 8'hff;
    // ****************************************
    // Source select codes
    // ****************************************
    localparam logic [2:0] FPS_SEL_0 = 3'h0;
    localparam logic [2:0] FPS_SEL_1 = 3'h1;
    localparam logic [2:0] FPS_SEL_2 = 3'h2;
    localparam logic [2:0] FPS_SEL_3 = 3'h3;
    localparam logic [2:0] FPS_SEL_4 = 3'h4;
    localparam logic [2:0] FPS_SEL_5 = 3'h5;
    localparam logic [2:0] FPS_SEL_6 = 3'h6;
    localparam logic [2:0] FPS_SEL_7 = 3'h7;
    localparam int FPS_NCH = 3;
    typedef enum {FPS_IDLE, FPS_ACCESS} fps_bus_t;
endpackage : fps_pkg

// [hdl/fps_max_pick.sv]
`timescale 1ns/1ps
module fps_max_pick #(
    parameter int N = 4
) (
    // Candidates and enables
    input wire logic [N*8-1:0] dutyIn,
    input wire logic [N-1:0] useIn,
    // Largest enabled candidate
    output logic [7:0] dutyMax
);
    import fps_pkg::*;
    always_comb begin
        dutyMax = FPS_ZERO8;
        for (int i = 0; i < N; i++) begin
            if (useIn[i] && dutyIn[i*8 +: 8] > dutyMax) begin
                dutyMax = dutyIn[i*8 +: 8];
            end
        end
    end
endmodule : fps_max_pick

// [hdl/fps_channel_decode.sv]
`timescale 1ns/1ps
module fps_channel_decode (
    // Channel setting
    input wire logic [2:0] fanSourceSelect,
    input wire logic secondOptionSelect,
    input wire logic [7:0] manualDuty,
    // Candidate duties: remote1, local, remote2, cpu0..cpu3
    input wire logic [55:0] srcDuty,
    // Result
    output logic [7:0] dutyNxt,
    output logic outEnable,
    output logic manualMode
);
    import fps_pkg::*;
    logic [6:0] useSel;
    logic [7:0] maxDuty;
    fps_max_pick #(.N(7)) uPick (
        .dutyIn(srcDuty),
        .useIn(useSel),
        .dutyMax(maxDuty)
    );
    always_comb begin
        useSel = 7'h00;
        dutyNxt = FPS_FULL_DUTY;
        outEnable = 1'b1;
        manualMode = 1'b0;
        if (!secondOptionSelect) begin
            case (fanSourceSelect)
                FPS_SEL_0: useSel = 7'h01;
                FPS_SEL_1: useSel = 7'h02;
                FPS_SEL_2: useSel = 7'h04;
                FPS_SEL_3: useSel = 7'h00;
                FPS_SEL_4: outEnable = 1'b0;
                FPS_SEL_5: useSel = 7'h06;
                FPS_SEL_6: useSel = 7'h07;
                default: manualMode = 1'b1;
            endcase
        end else begin
            case (fanSourceSelect)
                FPS_SEL_0: useSel = 7'h08;
                FPS_SEL_1: useSel = 7'h10;
                FPS_SEL_2: useSel = 7'h20;
                FPS_SEL_3: useSel = 7'h40;
                FPS_SEL_5: useSel = 7'h78;
                FPS_SEL_7: useSel = 7'h7f;
                default: useSel = 7'h00;
            endcase
        end
        if (manualMode) begin
            dutyNxt = manualDuty;
        end else if (useSel != 7'h00) begin
            dutyNxt = maxDuty;
        end
    end
endmodule : fps_channel_decode

// [hdl/fan_pwm_source_select.sv]
// Notes on behaviour
// - Plain codes 0-2 pick remote1, local, remote2
// - Plain code 3 full speed, reset value
// - Plain code 4 disables the output
// - Plain code 5 max of local, remote2
// - Plain code 6 max of three temperatures
// - Plain code 7 manual, duty registers writable
// - Second option codes 0-3 pick cpu readings
// - Second option codes 4,6 run full duty
// - Second option code 5 max cpu reading
// - Second option code 7 max of all
// - Lock bit freezes config and channel registers; substitute register stays writable
// - Substitute mode forces channel 1 second option
// - Bits 7:5 code, bit 3 option, clear
`timescale 1ns/1ps
module fan_pwm_source_select (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Duty from temperature curves (same clock)
    input wire logic [7:0] remote1Duty,
    input wire logic [7:0] localDuty,
    input wire logic [7:0] remote2Duty,
    input wire logic [7:0] cpuReading0Duty,
    input wire logic [7:0] cpuReading1Duty,
    input wire logic [7:0] cpuReading2Duty,
    input wire logic [7:0] cpuReading3Duty,
    // Per-channel result
    output logic [fps_pkg::FPS_NCH*8-1:0] pwmDuty,
    output logic [fps_pkg::FPS_NCH-1:0] pwmEnable,
    output logic [fps_pkg::FPS_NCH-1:0] pwmManual,
    output logic configLocked
);
    import fps_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [FPS_NCH-1:0][7:0] chCfg;
        logic [FPS_NCH-1:0][7:0] manDuty;
        logic [FPS_NCH-1:0][7:0] duty;
        logic [FPS_NCH-1:0] enable;
        logic [FPS_NCH-1:0] manual;
        logic [7:0] subst;
        logic [7:0] cfg1;
        logic [31:0] rdata;
        logic slvErr;
    } fps_state_t;

    fps_state_t st_r;
    fps_state_t st_nxt;
    logic [55:0] srcDuty;
    logic [FPS_NCH*8-1:0] decDuty;
    logic [FPS_NCH-1:0] decEnable;
    logic [FPS_NCH-1:0] decManual;
    logic [FPS_NCH-1:0] effOption;
    logic access;
    logic [7:0] wByte;
    logic [7:0] addr8;
    logic [1:0] cfgIdx;
    logic [1:0] dutyIdx;

    assign srcDuty = {cpuReading3Duty, cpuReading2Duty, cpuReading1Duty, cpuReading0Duty,
                      remote2Duty, localDuty, remote1Duty};
    assign access = psel && penable;
    assign wByte = pwdata[7:0];
    assign addr8 = paddr[7:0];
    // Channel index within each register group
    assign cfgIdx = 2'(addr8 - FPS_ADDR_CH1);
    assign dutyIdx = 2'(addr8 - FPS_ADDR_DUTY1);

    // ****************************************
    // Per-channel decode
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < FPS_NCH; g++) begin : gCh
            if (g == 0) begin : gSub
                assign effOption[g] = st_r.chCfg[g][FPS_ALT_BIT] | st_r.subst[FPS_SUBST_BIT];
            end else begin : gPlain
                assign effOption[g] = st_r.chCfg[g][FPS_ALT_BIT];
            end
            fps_channel_decode uDec (
                .fanSourceSelect(st_r.chCfg[g][FPS_SEL_MSB:FPS_SEL_LSB]),
                .secondOptionSelect(effOption[g]),
                .manualDuty(st_r.manDuty[g]),
                .srcDuty(srcDuty),
                .dutyNxt(decDuty[g*8 +: 8]),
                .outEnable(decEnable[g]),
                .manualMode(decManual[g])
            );
        end
    endgenerate

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < FPS_NCH; i++) begin
            st_nxt.duty[i] = decDuty[i*8 +: 8];
        end
        st_nxt.enable = decEnable;
        st_nxt.manual = decManual;
        st_nxt.slvErr = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        if (access && pwrite && pstrb[0]) begin
            if (paddr[11:8] != 4'h0) begin
                st_nxt.slvErr = 1'b1;
            end else if (addr8 == FPS_ADDR_CFG1) begin
                if (!st_r.cfg1[FPS_LOCK_BIT]) begin
                    st_nxt.cfg1 = wByte;
                end
            end else if (addr8 == FPS_ADDR_SUBST) begin
                st_nxt.subst = wByte;
            end else if (addr8 == FPS_ADDR_CH1 || addr8 == FPS_ADDR_CH2 ||
                         addr8 == FPS_ADDR_CH3) begin
                if (!st_r.cfg1[FPS_LOCK_BIT]) begin
                    st_nxt.chCfg[cfgIdx] = wByte;
                end
            end else if (addr8 == FPS_ADDR_DUTY1 || addr8 == FPS_ADDR_DUTY2 ||
                         addr8 == FPS_ADDR_DUTY3) begin
                if (decManual[dutyIdx]) begin
                    st_nxt.manDuty[dutyIdx] = wByte;
                end
            end else begin
                st_nxt.slvErr = 1'b1;
            end
        end else if (access && !pwrite) begin
            if (paddr[11:8] != 4'h0) begin
                st_nxt.slvErr = 1'b1;
            end else if (addr8 == FPS_ADDR_CFG1) begin
                st_nxt.rdata = {24'h000000, st_r.cfg1};
            end else if (addr8 == FPS_ADDR_SUBST) begin
                st_nxt.rdata = {24'h000000, st_r.subst};
            end else if (addr8 == FPS_ADDR_CH1 || addr8 == FPS_ADDR_CH2 ||
                         addr8 == FPS_ADDR_CH3) begin
                st_nxt.rdata = {24'h000000, st_r.chCfg[cfgIdx]};
            end else if (addr8 == FPS_ADDR_DUTY1 || addr8 == FPS_ADDR_DUTY2 ||
                         addr8 == FPS_ADDR_DUTY3) begin
                // Reads the live duty of the channel
                st_nxt.rdata = {24'h000000, st_r.duty[dutyIdx]};
            end else begin
                st_nxt.slvErr = 1'b1;
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < FPS_NCH; i++) begin
                st_r.chCfg[i] <= FPS_CH_RESET;
                st_r.manDuty[i] <= FPS_DUTY_RESET;
                st_r.duty[i] <= FPS_FULL_DUTY;
            end
            st_r.enable <= '1;
            st_r.manual <= '0;
            st_r.subst <= FPS_ZERO8;
            st_r.cfg1 <= FPS_ZERO8;
            st_r.rdata <= 32'h0000_0000;
            st_r.slvErr <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // APB answer: one wait state
    // ****************************************
    logic wait_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= access && !wait_r;
        end
    end
    assign pready = wait_r;
    assign prdata = st_r.rdata;
    assign pslverr = wait_r && st_r.slvErr;
    assign pwmDuty = st_r.duty;
    assign pwmEnable = st_r.enable;
    assign pwmManual = st_r.manual;
    assign configLocked = st_r.cfg1[FPS_LOCK_BIT];
endmodule : fan_pwm_source_select

// [verif/fps_asserts.sv]
`timescale 1ns/1ps
module fps_asserts (
    // Bus
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // Fan side
    input wire logic [fps_pkg::FPS_NCH*8-1:0] pwmDuty,
    input wire logic [fps_pkg::FPS_NCH-1:0] pwmEnable,
    input wire logic [fps_pkg::FPS_NCH-1:0] pwmManual,
    input wire logic configLocked
);
    import fps_pkg::*;
    // ****************
    // Helpers
    // ****************
    wire mapped = paddr inside {12'h030, 12'h031, 12'h032, 12'h036, 12'h040, 12'h05c, 12'h05d,
        12'h05e};
    wire wrDone = psel && penable && pready && pwrite && pstrb[0];
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_setup; psel && !penable; endsequence
    sequence s_first; psel && penable && !pready; endsequence
    property p_answer; s_setup ##1 s_first |=> pready; endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready longer than one cycle");
    property p_err; pready && (pstrb[0] || !pwrite) |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err)
        else $error("error flag wrong for address");
    property p_lockset; wrDone && paddr == 12'h040 && pwdata[0] |=> configLocked; endproperty
    a_lockset: assert property (p_lockset)
        else $error("lock not set by write");
    property p_lockhold; configLocked |=> configLocked; endproperty
    a_lockhold: assert property (p_lockhold)
        else $error("lock cleared without reset");
    property p_reset;
        $fell(rst) |-> pwmEnable == 3'h7 && pwmManual == 3'h0 && !configLocked
            && pwmDuty == 24'hffffff;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs wrong after reset");
    property p_disable; !pwmEnable[1] |-> pwmDuty[15:8] == FPS_FULL_DUTY; endproperty
    a_disable: assert property (p_disable)
        else $error("disabled channel duty wrong");
    property p_manen; pwmManual[1] |-> pwmEnable[1]; endproperty
    a_manen: assert property (p_manen)
        else $error("manual channel disabled");
    property p_manual;
        wrDone && paddr == 12'h031 && pwmManual[1] |=> pwmDuty[15:8] == $past(pwdata[7:0]);
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual duty not applied");
endmodule : fps_asserts

bind fan_pwm_source_select fps_asserts u_chk (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .pwmDuty(pwmDuty), .pwmEnable(pwmEnable),
    .pwmManual(pwmManual), .configLocked(configLocked));

// [verif/tb_fan_pwm_source_select.sv]
`timescale 1ns/1ps
module tb_fan_pwm_source_select;
    import fps_pkg::*;
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] du [7] = '{default: 8'h00};
    logic [7:0] man = 8'hff, cfg, v;
    logic [8:0] e;
    logic [8:0] expq [$];
    logic [31:0] seed = 32'h25;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, configLocked;
    wire logic [23:0] pwmDuty;
    wire logic [2:0] pwmEnable, pwmManual;
    int fails = 0, n_checks = 0, cyc = 0;
    always #2 clock = ~clock;
    fan_pwm_source_select dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .remote1Duty(du[0]), .localDuty(du[1]),
        .remote2Duty(du[2]), .cpuReading0Duty(du[3]), .cpuReading1Duty(du[4]),
        .cpuReading2Duty(du[5]), .cpuReading3Duty(du[6]), .pwmDuty(pwmDuty),
        .pwmEnable(pwmEnable), .pwmManual(pwmManual), .configLocked(configLocked));
    // ****************
    // Helpers
    // ****************
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] mx(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction : mx
    function automatic logic [8:0] expect_out(input logic [2:0] c, input logic a);
        logic [7:0] t3, c4;
        t3 = mx(mx(du[0], du[1]), du[2]);
        c4 = mx(mx(du[3], du[4]), mx(du[5], du[6]));
        if (a) begin
            if (c == 3'h4 || c == 3'h6) return 9'h1ff;
            if (c == 3'h5) return {1'b1, c4};
            if (c == 3'h7) return {1'b1, mx(t3, c4)};
            return {1'b1, du[3 + c]};
        end
        if (c == 3'h3) return 9'h1ff;
        if (c == 3'h4) return 9'h0ff;
        if (c == 3'h5) return {1'b1, mx(du[1], du[2])};
        if (c == 3'h6) return {1'b1, t3};
        if (c == 3'h7) return {1'b1, man};
        return {1'b1, du[c]};
    endfunction : expect_out
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {4'h0, a};
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [8:0] x);
        expq.push_back(x);
        xfer(1'b0, a, 8'h00);
    endtask : rd
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            fails++;
            conclude();
        end
        if (psel && penable && pready && !pwrite) begin
            check({3'h0, pslverr, pslverr ? 8'h00 : prdata[7:0]}, {3'h0, expq.pop_front()});
            check({4'h0, prdata[31:24] | prdata[23:16] | prdata[15:8]}, 12'h000);
        end
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(FPS_ADDR_CH1, 9'h062);
        rd(FPS_ADDR_CH3, 9'h062);
        rd(FPS_ADDR_DUTY2, 9'h0ff);
        rd(FPS_ADDR_CFG1, 9'h000);
        rd(8'h10, 9'h100);
        xfer(1'b1, 8'h10, 8'h55);
        for (int k = 0; k < 16; k++) begin
            for (int i = 0; i < 7; i++) du[i] <= rnd();
            cfg = {k[2:0], 1'b0, k[3], 3'h2};
            xfer(1'b1, FPS_ADDR_CH2, cfg);
            v = rnd();
            xfer(1'b1, FPS_ADDR_DUTY1, v);
            xfer(1'b1, FPS_ADDR_DUTY2, v);
            if (k == 7) man = v;
            e = expect_out(k[2:0], k[3]);
            rd(FPS_ADDR_CH2, {1'b0, cfg});
            rd(FPS_ADDR_DUTY2, {1'b0, e[7:0]});
            rd(FPS_ADDR_DUTY1, 9'h0ff);
            check({9'h0, pwmEnable}, {9'h0, 1'b1, e[8], 1'b1});
            check({9'h0, pwmManual}, {10'h0, k == 7, 1'b0});
            check({4'h0, pwmDuty[15:8]}, {4'h0, e[7:0]});
            check({4'h0, pwmDuty[23:16]}, 12'h0ff);
        end
        xfer(1'b1, FPS_ADDR_SUBST, 8'h10);
        xfer(1'b1, FPS_ADDR_CH1, 8'h02);
        rd(FPS_ADDR_SUBST, 9'h010);
        rd(FPS_ADDR_DUTY1, {1'b0, du[3]});
        check({4'h0, pwmDuty[7:0]}, {4'h0, du[3]});
        xfer(1'b1, FPS_ADDR_CFG1, 8'h01);
        check({11'h0, configLocked}, 12'h001);
        xfer(1'b1, FPS_ADDR_CH1, 8'h62);
        xfer(1'b1, FPS_ADDR_CFG1, 8'h00);
        rd(FPS_ADDR_CH1, 9'h002);
        rd(FPS_ADDR_CFG1, 9'h001);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(FPS_ADDR_CFG1, 9'h000);
        rd(FPS_ADDR_CH1, 9'h062);
        repeat (2) @(posedge clock);
        conclude();
    end
endmodule : tb_fan_pwm_source_select
